// ===== hw/dppc_cfg.svh
`ifndef DPPC_CFG_SVH
`define DPPC_CFG_SVH
// Default number of downstream ports
`define DPPC_NUM_PORTS       4
// Default filter length in consecutive low samples
`define DPPC_FILT_DEFAULT    8'h10
// Width of the filter counter and threshold
`define DPPC_FILT_W          8
// Ports allowed to split, bit n is port n+1
`define DPPC_SPLIT_OK_CFG1   4'he
`define DPPC_SPLIT_OK_CFG2   4'h8
// Pin configuration codes
`define DPPC_PINCFG_1        2'h1
`define DPPC_PINCFG_2        2'h2
`endif

// ===== hw/dppc_pkg.sv
package dppc_pkg;
   // Who owns port power decisions
   typedef enum logic [1:0]
   {
      DPPC_CTRL_HUB = 2'h1,
      DPPC_CTRL_CPU = 2'h2
   } dppc_ctrl_type;
endpackage

// ===== hw/dppc_top.sv
// Notes on behaviour
// - Per-port battery charging forces primary pin power on, not the SuperSpeed pin of a split port
// - One shared power and sense pin each
// - Power off: drive low, pull-up off
// - Power on: release driver, pull-up on
// - Low while powered means over-current
// - Filter transient lows on sense input
// - Blown fuse low also means over-current
// - Hub logic or processor controls power
// - Reset leaves every port non-split
// - Split allowed only on permitted ports
// - Non-split pin serves both halves
// - Split adds separate SuperSpeed pin
`timescale 1ns/100ps
`include "dppc_cfg.svh"

module dppc_top #(
   parameter int                  NUM_PORTS = `DPPC_NUM_PORTS,
   parameter int                  FILT_W    = `DPPC_FILT_W
)(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic [1:0]           pin_config,
   input  wire dppc_pkg::dppc_ctrl_type ctrl_source,
   input  wire logic [NUM_PORTS-1:0] hub_power_req,
   input  wire logic [NUM_PORTS-1:0] hub_ss_power_req,
   input  wire logic [NUM_PORTS-1:0] cpu_power_req,
   input  wire logic [NUM_PORTS-1:0] cpu_ss_power_req,
   input  wire logic [NUM_PORTS-1:0] charge_enable,
   input  wire logic [NUM_PORTS-1:0] split_request,
   input  wire logic [FILT_W-1:0]    filter_length,
   input  wire logic [NUM_PORTS-1:0] overcurrent_clear,
   input  wire logic [NUM_PORTS-1:0] port_power_sense_pin_in,
   input  wire logic [NUM_PORTS-1:0] superspeed_power_sense_pin_in,
   output logic      [NUM_PORTS-1:0] port_power_sense_pin_out,
   output logic      [NUM_PORTS-1:0] port_power_sense_pin_oe_n,
   output logic      [NUM_PORTS-1:0] port_pullup_en,
   output logic      [NUM_PORTS-1:0] superspeed_power_sense_pin_out,
   output logic      [NUM_PORTS-1:0] superspeed_power_sense_pin_oe_n,
   output logic      [NUM_PORTS-1:0] superspeed_pullup_en,
   output logic      [NUM_PORTS-1:0] port_half_separation,
   output logic      [NUM_PORTS-1:0] usb2_power_on,
   output logic      [NUM_PORTS-1:0] superspeed_power_on,
   output logic      [NUM_PORTS-1:0] usb2_overcurrent_sense,
   output logic      [NUM_PORTS-1:0] superspeed_overcurrent_sense
);

   //***********************************************************
   // Control selection and split permission
   //***********************************************************
   logic [NUM_PORTS-1:0] split_ok;
   logic [NUM_PORTS-1:0] split_q;
   logic [NUM_PORTS-1:0] split_d;
   logic [NUM_PORTS-1:0] pri_req;
   logic [NUM_PORTS-1:0] ss_req;
   logic [NUM_PORTS-1:0] pri_pwr_q;
   logic [NUM_PORTS-1:0] pri_pwr_d;
   logic [NUM_PORTS-1:0] ss_pwr_q;
   logic [NUM_PORTS-1:0] ss_pwr_d;
   logic [NUM_PORTS-1:0] pri_oc_q;
   logic [NUM_PORTS-1:0] ss_oc_q;
   logic                 cpu_sel;
   logic [3:0]           split_mask;

   assign cpu_sel = (ctrl_source == dppc_pkg::DPPC_CTRL_CPU);
   assign pri_req = cpu_sel ? cpu_power_req : hub_power_req;
   assign ss_req  = cpu_sel ? cpu_ss_power_req : hub_ss_power_req;

   assign split_mask =
      (pin_config == `DPPC_PINCFG_1) ? `DPPC_SPLIT_OK_CFG1 :
      (pin_config == `DPPC_PINCFG_2) ? `DPPC_SPLIT_OK_CFG2 : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_ok
         if (gi < 4)
         begin : g_in
            assign split_ok[gi] = split_mask[gi];
         end
         else
         begin : g_out
            assign split_ok[gi] = 1'b0;
         end
      end
   endgenerate

   assign split_d = split_request & split_ok;

   // charging asks for power on the primary pin
   // shared pin drives both halves when not split
   assign pri_pwr_d = pri_req | charge_enable;
   assign ss_pwr_d  = split_q & ss_req;

   //***********************************************************
   // Registers
   //***********************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         split_q   <= '0;
         pri_pwr_q <= '0;
         ss_pwr_q  <= '0;
      end
      else
      begin
         split_q   <= split_d;
         pri_pwr_q <= pri_pwr_d;
         ss_pwr_q  <= ss_pwr_d;
      end
   end

   //***********************************************************
   // Per-port sense low detect and over-current filter
   //***********************************************************
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_port
         logic [FILT_W-1:0] pcnt_q;
         logic [FILT_W-1:0] pcnt_d;
         logic [FILT_W-1:0] scnt_q;
         logic [FILT_W-1:0] scnt_d;
         logic              plow;
         logic              slow;
         logic              phit;
         logic              shit;
         logic              poc_q;
         logic              soc_q;

         // Latched flags gathered into the port vectors
         assign pri_oc_q[gi] = poc_q;
         assign ss_oc_q[gi]  = soc_q;

         // fuse low same path
         // Own drive low before release is not a fault
         assign plow = port_power_sense_pin_oe_n[gi] &
                       ~port_power_sense_pin_in[gi];
         assign slow = superspeed_power_sense_pin_oe_n[gi] &
                       ~superspeed_power_sense_pin_in[gi];

         assign pcnt_d = !plow ? '0 :
                         (pcnt_q == '1) ? pcnt_q : pcnt_q + 1'b1;
         assign scnt_d = !slow ? '0 :
                         (scnt_q == '1) ? scnt_q : scnt_q + 1'b1;
         assign phit = plow & (pcnt_d >= filter_length);
         assign shit = slow & (scnt_d >= filter_length);

         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               pcnt_q <= '0;
               scnt_q <= '0;
               poc_q  <= 1'b0;
               soc_q  <= 1'b0;
            end
            else
            begin
               pcnt_q <= pcnt_d;
               scnt_q <= scnt_d;
               poc_q  <= phit | (poc_q & ~overcurrent_clear[gi]);
               soc_q  <= shit | (soc_q & ~overcurrent_clear[gi]);
            end
         end
      end
   endgenerate

   //***********************************************************
   // Output flops
   //***********************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         port_power_sense_pin_out        <= '0;
         port_power_sense_pin_oe_n       <= '0;
         port_pullup_en                  <= '0;
         superspeed_power_sense_pin_out  <= '0;
         superspeed_power_sense_pin_oe_n <= '0;
         superspeed_pullup_en            <= '0;
         port_half_separation            <= '0;
         usb2_power_on                   <= '0;
         superspeed_power_on             <= '0;
         usb2_overcurrent_sense          <= '0;
         superspeed_overcurrent_sense    <= '0;
      end
      else
      begin
         // one shared pin, drive low when off
         // release and pull up when on
         port_power_sense_pin_out        <= '0;
         port_power_sense_pin_oe_n       <= pri_pwr_q;
         port_pullup_en                  <= pri_pwr_q;
         // second pin used only when split
         superspeed_power_sense_pin_out  <= '0;
         superspeed_power_sense_pin_oe_n <= ss_pwr_q;
         superspeed_pullup_en            <= ss_pwr_q;
         port_half_separation            <= split_q;
         usb2_power_on                   <= pri_pwr_q;
         superspeed_power_on    <= (split_q & ss_pwr_q) |
                                   (~split_q & pri_pwr_q);
         usb2_overcurrent_sense <= pri_oc_q;
         superspeed_overcurrent_sense <= (split_q & ss_oc_q) |
                                         (~split_q & pri_oc_q);
      end
   end

endmodule // dppc_top

// ===== test/dppc_switch_model.sv
`timescale 1ns/100ps
module dppc_switch_model (
   input  wire logic [3:0] oe_n, pullup_en, fault,
   output wire logic [3:0] pin
);
   assign pin = oe_n & pullup_en & ~fault;
endmodule // dppc_switch_model

// ===== test/dppc_monitor.sv
`timescale 1ns/100ps
module dppc_monitor #(parameter int NUM_PORTS = 4, FILT_W = 8)(
   input wire logic sys_clk, rst_n,
   input wire dppc_pkg::dppc_ctrl_type ctrl_source,
   input wire logic [FILT_W-1:0] filter_length,
   input wire logic [NUM_PORTS-1:0] cpu_power_req, charge_enable,
   input wire logic [NUM_PORTS-1:0] overcurrent_clear, port_pullup_en,
   input wire logic [NUM_PORTS-1:0] port_power_sense_pin_in,
   input wire logic [NUM_PORTS-1:0] port_power_sense_pin_oe_n,
   input wire logic [NUM_PORTS-1:0] port_half_separation, usb2_power_on,
   input wire logic [NUM_PORTS-1:0] usb2_overcurrent_sense
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_low;
      (usb2_power_on[0] && !port_power_sense_pin_in[0]
         && filter_length == 8'h03) [*4];
   endsequence
   sequence s_clr;
      (overcurrent_clear[0] && port_power_sense_pin_in[0]) [*3];
   endsequence
   property p_off;
      port_power_sense_pin_oe_n == usb2_power_on
         && port_pullup_en == usb2_power_on;
   endproperty
   a_off: assert property (p_off) else $error("pin drive");
   property p_chg;
      $past(rst_n, 2) |-> &(usb2_power_on | ~$past(charge_enable, 2));
   endproperty
   a_chg: assert property (p_chg) else $error("charging");
   property p_cpu;
      $past(rst_n, 2) && $past(ctrl_source, 2) == dppc_pkg::DPPC_CTRL_CPU
         |-> usb2_power_on == ($past(cpu_power_req, 2)
         | $past(charge_enable, 2));
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu power");
   property p_rst; $rose(rst_n) |-> ~|port_half_separation; endproperty
   a_rst: assert property (p_rst) else $error("reset split");
   property p_p1; !port_half_separation[0]; endproperty
   a_p1: assert property (p_p1) else $error("port 1 split");
   property p_set; s_low |-> ##[1:3] usb2_overcurrent_sense[0]; endproperty
   a_set: assert property (p_set) else $error("no flag");
   property p_flt;
      $rose(usb2_overcurrent_sense[0]) |-> !$past(port_power_sense_pin_in[0],
         2) && !$past(port_power_sense_pin_in[0], 3);
   endproperty
   a_flt: assert property (p_flt) else $error("short low");
   property p_clr; s_clr |=> !usb2_overcurrent_sense[0]; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
endmodule // dppc_monitor
bind dppc_top dppc_monitor #(.NUM_PORTS(NUM_PORTS), .FILT_W(FILT_W))
   i_dppc_monitor (.*);

// ===== test/dppc_top_tb.sv
`timescale 1ns/100ps
module dppc_top_tb;
   logic sys_clk = 1'b0, rst_n = 1'b0;
   logic [1:0] pin_config = 2'h0;
   logic [7:0] filter_length = 8'h03;
   dppc_pkg::dppc_ctrl_type ctrl_source = dppc_pkg::DPPC_CTRL_HUB;
   logic [3:0] hub_power_req = 4'h0, hub_ss_power_req = 4'h0,
      cpu_power_req = 4'h0, cpu_ss_power_req = 4'h0, charge_enable = 4'h0,
      split_request = 4'h0, overcurrent_clear = 4'h0, fault = 4'h0,
      ss_fault = 4'h0;
   logic [3:0] port_power_sense_pin_in, superspeed_power_sense_pin_in,
      port_power_sense_pin_out, port_power_sense_pin_oe_n, port_pullup_en,
      superspeed_power_sense_pin_out, superspeed_power_sense_pin_oe_n,
      superspeed_pullup_en, port_half_separation, usb2_power_on,
      superspeed_power_on, usb2_overcurrent_sense,
      superspeed_overcurrent_sense;
   int fails = 0, compares = 0;
   dppc_top i_dppc_top (.*);
   dppc_switch_model i_dppc_switch_model (.oe_n(port_power_sense_pin_oe_n),
      .pullup_en(port_pullup_en), .fault, .pin(port_power_sense_pin_in));
   dppc_switch_model i_dppc_switch_model_ss (
      .oe_n(superspeed_power_sense_pin_oe_n), .pullup_en(superspeed_pullup_en),
      .fault(ss_fault), .pin(superspeed_power_sense_pin_in));
   task automatic w(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(string n, logic [3:0] s, e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_power;
      chk("oe_n", port_power_sense_pin_oe_n, 4'h0);
      chk("split", port_half_separation, 4'h0);
      hub_power_req <= 4'h5;
      w(4);
      chk("oe_n", port_power_sense_pin_oe_n, 4'h5);
      chk("pull-up", port_pullup_en, 4'h5);
      chk("drive", port_power_sense_pin_out, 4'h0);
      chk("ss power", superspeed_power_on, 4'h5);
      ctrl_source <= dppc_pkg::DPPC_CTRL_CPU;
      cpu_power_req <= 4'h9;
      charge_enable <= 4'h2;
      w(4);
      chk("cpu power", usb2_power_on, 4'hb);
   endtask
   task automatic t_overcurrent;
      fault <= 4'h3;
      w(2);
      fault <= 4'h0;
      w(8);
      chk("glitch", usb2_overcurrent_sense, 4'h0);
      fault <= 4'h5;
      w(8);
      chk("flag", usb2_overcurrent_sense, 4'h1);
      chk("ss flag", superspeed_overcurrent_sense, 4'h1);
      fault <= 4'h0;
      overcurrent_clear <= 4'h1;
      w(4);
      overcurrent_clear <= 4'h0;
      chk("clear", usb2_overcurrent_sense, 4'h0);
   endtask
   task automatic t_split;
      split_request <= 4'hf;
      pin_config <= 2'h2;
      w(4);
      chk("cfg2", port_half_separation, 4'h8);
      pin_config <= 2'h1;
      cpu_ss_power_req <= 4'h4;
      ss_fault <= 4'h4;
      w(10);
      chk("cfg1", port_half_separation, 4'he);
      chk("ss on", superspeed_power_on, 4'h5);
      chk("ss flag", superspeed_overcurrent_sense, 4'h4);
      chk("u2 flag", usb2_overcurrent_sense, 4'h0);
      chk("ss oe_n", superspeed_power_sense_pin_oe_n, 4'h4);
      chk("ss pull-up", superspeed_pullup_en, 4'h4);
      chk("ss drive", superspeed_power_sense_pin_out, 4'h0);
   endtask
   task automatic t_reset;
      rst_n <= 1'b0;
      w(2);
      rst_n <= 1'b1;
      w(1);
      chk("rst split", port_half_separation, 4'h0);
      chk("rst oe_n", port_power_sense_pin_oe_n, 4'h0);
      chk("rst ss flag", superspeed_overcurrent_sense, 4'h0);
      w(2);
      chk("rst resume", port_half_separation, 4'he);
   endtask
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   initial
   begin
      w(3000);
      fails++;
      print_verdict;
   end
   initial
   begin
      w(6);
      rst_n <= 1'b1;
      w(2);
      t_power;
      t_overcurrent;
      t_split;
      t_reset;
      print_verdict;
   end
endmodule // dppc_top_tb
